/* File: inc/bert_pkg.sv */
// constants, field layouts and types of the bit error rate tester
// assumes one 20 MHz datapath clock and an AXI4-Lite register slave
// How it works
// - pseudo-random polynomials x^n + x^y + 1, n up to 32, tap below n
// - repetitive patterns of 1 to 32 bits, any n-bit value
// - 24-bit error count and 32-bit bit count readable by software
// - errors inserted singly or one per 10^n bits, n 1 to 7 or off
// - single error from register write or manual input, chosen by configuration
// - patterns load only on a 0-to-1 change of the load bits
// - nonzero flag reads one while the error count is one or more
// - six mismatches in a 64-bit window drop sync and start resync
// - update event captures counts since last update and clears live counters
// - checker takes payload bits only; stream passes on unchanged
// - receive generator: 32-bit shift, feedback n xor y or bit n, output is feedback
// - transmit generator uses the same structure and feeds error insertion
// - quasi-random: feedback 17 xor 20, output one after 14 zero bits
// - pseudo and quasi-random feedback forced one when bits 1..31 are zero
// - pseudo-random sync loads 32 bits then needs 32 matching bits
// - repetitive sync searches each bit position, then needs 32 matches
// - automatic resync can be switched off
// - out-of-sync flag high whenever the sync machine is not in sync
// - mismatch counts error and bit, match counts bit only
// - no counting while out of sync
// - transmit generator preset with seed or pattern on a load
// - optional inversion of generated data ahead of overhead insertion
package bert_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] PCFG_OFS = 8'h04;
	localparam logic [7:0] SEED_OFS = 8'h08;
	localparam logic [7:0] RATE_OFS = 8'h0C;
	localparam logic [7:0] STAT_OFS = 8'h10;
	localparam logic [7:0] BITS_OFS = 8'h14;
	localparam logic [7:0] ERRS_OFS = 8'h18;
	localparam int CB_EN = 0;
	localparam int CB_TXL = 1;
	localparam int CB_RXL = 2;
	localparam int CB_SERR = 3;
	localparam int CB_LOCAL_MONITOR_UPDATE = 4;
	localparam int CB_TINV = 5;
	localparam int CB_RINV = 6;
	localparam int CB_PSRC = 7;
	localparam int CB_ARDIS = 8;
	localparam int PC_LEN = 0;
	localparam int PC_TAP = 8;
	localparam int PC_PTS = 16;
	localparam int PC_QUASI_RANDOM_MODE = 17;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************
	// pattern and sync constants
	// ****************************************
	localparam int QR_TAP_A = 16;
	localparam int QR_TAP_B = 19;
	localparam int QR_ZRUN = 14;
	localparam logic [4:0] SYNC_LAST = 5'h1F;
	localparam logic [5:0] WIN_LAST = 6'h3F;
	localparam logic [2:0] RESYNC_ERRS = 3'h6;
	typedef struct packed {
		logic rep;
		logic quasi_random_mode;
		logic [4:0] tap;
		logic [4:0] len;
	} pat_cfg_s;
	typedef enum logic [2:0] {
		RX_HUNT = 3'h1,
		RX_VERIFY = 3'h2,
		RX_SYNC = 3'h4
	} rx_st_e;
	// terminal count of one error per 10^n bits
	function automatic logic [23:0] rate_last(input logic [2:0] n);
		unique case (n)
			3'h1: rate_last = 24'h000009;
			3'h2: rate_last = 24'h000063;
			3'h3: rate_last = 24'h0003E7;
			3'h4: rate_last = 24'h00270F;
			3'h5: rate_last = 24'h01869F;
			3'h6: rate_last = 24'h0F423F;
			3'h7: rate_last = 24'h98967F;
			default: rate_last = 24'hFFFFFF;
		endcase
	endfunction : rate_last
endpackage : bert_pkg

/* File: logic/pattern_gen.sv */
// 32-bit pattern shift generator, shared by both directions
// assumes the caller steps it once per payload bit
`timescale 1ns/1ns
module pattern_gen (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration
	input wire bert_pkg::pat_cfg_s cfg,
	input wire logic [31:0] seed,
	// control
	input wire logic preset,
	input wire logic step,
	input wire logic use_data,
	input wire logic data_in,
	// result
	output logic out_bit,
	output logic [31:0] sr
);
	import bert_pkg::*;
	typedef struct packed {
		logic [31:0] sr;
	} gen_s;
	gen_s st;
	gen_s nxt;
	logic fb;
	always_comb begin
		nxt = st;
		if (cfg.rep) begin
			fb = st.sr[cfg.len];
		end else if (cfg.quasi_random_mode) begin
			fb = st.sr[QR_TAP_A] ^ st.sr[QR_TAP_B];
		end else begin
			fb = st.sr[cfg.len] ^ st.sr[cfg.tap];
		end
		if (!cfg.rep && st.sr[30:0] == 31'h0) begin
			fb = 1'b1;
		end
		out_bit = fb | (cfg.quasi_random_mode & ~cfg.rep & (st.sr[QR_ZRUN-1:0] == 14'h0));
		if (preset) begin
			nxt.sr = seed;
		end else if (step) begin
			nxt.sr = {st.sr[30:0], use_data ? data_in : fb};
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= nxt;
		end
	end
	assign sr = st.sr;
	// ****************************************
	// checks
	// ****************************************
	chk_lockup_guard: assert property (@(posedge clk) disable iff (rst)
		(!cfg.rep && st.sr[30:0] == 31'h0) |-> out_bit)
		else $error("zero register did not force a one");
	chk_shift_feed: assert property (@(posedge clk) disable iff (rst)
		(step && !preset && !use_data) |=> (sr[0] == $past(fb) && sr[31:1] == $past(sr[30:0])))
		else $error("generator did not shift its feedback in");
endmodule : pattern_gen

/* File: logic/bert_core.sv */
// bit error rate tester: transmit pattern, error insertion, receive sync and counts
// assumes payload strobes from the framer datapath and an AXI4-Lite master
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module bert_core (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// axi write address and data
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [7:0] AWADDR,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	// axi write response
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	// axi read
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [7:0] ARADDR,
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	// transmit payload
	input wire logic TX_PAYLOAD_EN,
	output logic TX_DATA_OUT,
	output logic TX_DATA_VALID,
	input wire logic MANUAL_ERROR_INSERT_IN,
	// receive payload
	input wire logic RX_PAYLOAD_EN,
	input wire logic RX_DATA_IN,
	output logic RX_BACKPLANE_DATA,
	// monitor
	input wire logic MONITOR_UPDATE_EVENT,
	output logic OUT_OF_SYNC_FLAG,
	output logic ERROR_COUNT_NONZERO_FLAG
);
	import bert_pkg::*;
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic tester_enable;
		logic tx_pattern_load;
		logic rx_pattern_load;
		logic tx_pattern_invert;
		logic rx_pattern_invert;
		logic pin_source;
		logic resync_off;
		pat_cfg_s cfg;
		logic [31:0] seed;
		logic [2:0] rate;
		logic awrdy;
		logic aw_got;
		logic [7:0] aw_addr;
		logic wrdy;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic err_pend;
		logic pin_d;
		logic [23:0] rate_cnt;
		logic tx_bit;
		logic tx_vld;
		rx_st_e rx_st;
		logic [4:0] cnt;
		logic [5:0] win;
		logic [2:0] werr;
		logic [31:0] bit_cnt;
		logic [23:0] err_cnt;
		logic [31:0] bit_hold;
		logic [23:0] err_hold;
		logic nz;
		logic out_of_sync_flag;
		logic thru;
	} state_s;
	state_s st;
	state_s nxt;
	// byte-lane merge of a register write
	function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd, input logic [3:0] sb);
		logic [31:0] r;
		r = cur;
		for (int i = 0; i < 4; i++) begin
			if (sb[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge
	// generator links
	logic tx_preset;
	logic tx_step;
	logic tx_out;
	logic [31:0] tx_sr;
	logic rx_step;
	logic rx_use;
	logic rx_d;
	logic rx_out;
	logic [31:0] rx_sr;
	// helpers
	logic [31:0] cw;
	logic [31:0] mask;
	logic serr_wr;
	logic upd;
	logic rxl_rise;
	logic req;
	logic hit;
	logic ins;
	logic mis;
	logic bit_inc;
	logic err_inc;
	pattern_gen u_tx_gen (
		.clk(MCLK),
		.rst(RESET),
		.cfg(st.cfg),
		.seed(st.seed),
		.preset(tx_preset),
		.step(tx_step),
		.use_data(1'b0),
		.data_in(1'b0),
		.out_bit(tx_out),
		.sr(tx_sr)
	);
	pattern_gen u_rx_gen (
		.clk(MCLK),
		.rst(RESET),
		.cfg(st.cfg),
		.seed(st.seed),
		.preset(1'b0),
		.step(rx_step),
		.use_data(rx_use),
		.data_in(rx_d),
		.out_bit(rx_out),
		.sr(rx_sr)
	);
	always_comb begin
		nxt = st;
		tx_preset = 1'b0;
		tx_step = 1'b0;
		rx_step = 1'b0;
		rx_use = 1'b0;
		serr_wr = 1'b0;
		upd = MONITOR_UPDATE_EVENT;
		rxl_rise = 1'b0;
		cw = 32'h0;
		// ****************************************
		// axi write
		// ****************************************
		if (AWVALID && st.awrdy) begin
			nxt.aw_got = 1'b1;
			nxt.aw_addr = AWADDR;
		end
		if (WVALID && st.wrdy) begin
			nxt.w_got = 1'b1;
			nxt.wdata = WDATA;
			nxt.wstrb = WSTRB;
		end
		if (st.bvalid && BREADY) begin
			nxt.bvalid = 1'b0;
		end
		if (st.aw_got && st.w_got && !st.bvalid) begin
			nxt.aw_got = 1'b0;
			nxt.w_got = 1'b0;
			nxt.bvalid = 1'b1;
			nxt.bresp = RESP_OKAY;
			unique case (st.aw_addr)
				CTRL_OFS: begin
					cw = merge({23'h0, st.resync_off, st.pin_source, st.rx_pattern_invert,
						st.tx_pattern_invert, 2'h0, st.rx_pattern_load, st.tx_pattern_load,
						st.tester_enable}, st.wdata, st.wstrb);
					nxt.tester_enable = cw[CB_EN];
					nxt.tx_pattern_load = cw[CB_TXL];
					nxt.rx_pattern_load = cw[CB_RXL];
					nxt.tx_pattern_invert = cw[CB_TINV];
					nxt.rx_pattern_invert = cw[CB_RINV];
					nxt.pin_source = cw[CB_PSRC];
					nxt.resync_off = cw[CB_ARDIS];
					serr_wr = cw[CB_SERR];
					upd = upd | cw[CB_LOCAL_MONITOR_UPDATE];
					tx_preset = cw[CB_TXL] & ~st.tx_pattern_load & cw[CB_EN];
					rxl_rise = cw[CB_RXL] & ~st.rx_pattern_load & cw[CB_EN];
				end
				PCFG_OFS: begin
					cw = merge({14'h0, st.cfg.quasi_random_mode, st.cfg.rep, 3'h0, st.cfg.tap, 3'h0, st.cfg.len},
						st.wdata, st.wstrb);
					nxt.cfg.len = cw[PC_LEN +: 5];
					nxt.cfg.tap = cw[PC_TAP +: 5];
					nxt.cfg.rep = cw[PC_PTS];
					nxt.cfg.quasi_random_mode = cw[PC_QUASI_RANDOM_MODE];
				end
				SEED_OFS: begin
					nxt.seed = merge(st.seed, st.wdata, st.wstrb);
				end
				RATE_OFS: begin
					cw = merge({29'h0, st.rate}, st.wdata, st.wstrb);
					nxt.rate = cw[2:0];
					nxt.rate_cnt = 24'h0;
				end
				STAT_OFS, BITS_OFS, ERRS_OFS: begin
				end
				default: begin
					nxt.bresp = RESP_SLVERR;
				end
			endcase
		end
		nxt.awrdy = ~nxt.aw_got;
		nxt.wrdy = ~nxt.w_got;
		// ****************************************
		// axi read
		// ****************************************
		if (st.rvalid && RREADY) begin
			nxt.rvalid = 1'b0;
		end
		if (ARVALID && st.arrdy) begin
			nxt.rvalid = 1'b1;
			nxt.rresp = RESP_OKAY;
			unique case (ARADDR)
				CTRL_OFS: nxt.rdata = {23'h0, st.resync_off, st.pin_source, st.rx_pattern_invert,
					st.tx_pattern_invert, 2'h0, st.rx_pattern_load, st.tx_pattern_load, st.tester_enable};
				PCFG_OFS: nxt.rdata = {14'h0, st.cfg.quasi_random_mode, st.cfg.rep, 3'h0, st.cfg.tap, 3'h0, st.cfg.len};
				SEED_OFS: nxt.rdata = st.seed;
				RATE_OFS: nxt.rdata = {29'h0, st.rate};
				STAT_OFS: nxt.rdata = {30'h0, st.out_of_sync_flag, st.nz};
				BITS_OFS: nxt.rdata = st.bit_hold;
				ERRS_OFS: nxt.rdata = {8'h0, st.err_hold};
				default: begin
					nxt.rdata = 32'h0;
					nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
		nxt.arrdy = ~nxt.rvalid;
		// ****************************************
		// transmit
		// ****************************************
		// pin requests act on the rising edge, so a held pin gives one error
		nxt.pin_d = MANUAL_ERROR_INSERT_IN;
		// a source written together with a request already governs that request
		req = nxt.pin_source ? (MANUAL_ERROR_INSERT_IN & ~st.pin_d) : serr_wr;
		tx_step = TX_PAYLOAD_EN & st.tester_enable & ~tx_preset;
		hit = (st.rate != 3'h0) && (st.rate_cnt == rate_last(st.rate));
		ins = tx_step & (st.err_pend | hit);
		nxt.tx_vld = tx_step;
		if (tx_step) begin
			nxt.tx_bit = tx_out ^ ins ^ st.tx_pattern_invert;
			nxt.rate_cnt = hit ? 24'h0 : st.rate_cnt + 24'h1;
		end
		// a request in the cycle of an insertion survives to the next bit
		nxt.err_pend = (st.err_pend & ~(tx_step & st.err_pend)) | req;
		// ****************************************
		// receive
		// ****************************************
		nxt.thru = RX_DATA_IN;
		rx_d = RX_DATA_IN ^ st.rx_pattern_invert;
		mis = rx_out != rx_d;
		bit_inc = 1'b0;
		mask = 32'hFFFFFFFF >> (5'h1F - st.cfg.len);
		if (RX_PAYLOAD_EN && st.tester_enable) begin
			rx_step = 1'b1;
			unique case (st.rx_st)
				RX_HUNT: begin
					rx_use = 1'b1;
					nxt.cnt = st.cnt + 5'h1;
					if (st.cfg.rep) begin
						if ((({rx_sr[30:0], rx_d} ^ st.seed) & mask) == 32'h0) begin
							nxt.rx_st = RX_VERIFY;
							nxt.cnt = 5'h0;
						end
					end else if (st.cnt == SYNC_LAST) begin
						nxt.rx_st = RX_VERIFY;
					end
				end
				RX_VERIFY: begin
					nxt.cnt = st.cnt + 5'h1;
					if (mis) begin
						nxt.rx_st = RX_HUNT;
						nxt.cnt = 5'h0;
					end else if (st.cnt == SYNC_LAST) begin
						nxt.rx_st = RX_SYNC;
						nxt.win = 6'h0;
						nxt.werr = 3'h0;
					end
				end
				RX_SYNC: begin
					bit_inc = 1'b1;
					nxt.win = st.win + 6'h1;
					nxt.werr = st.werr + {2'h0, mis};
					if (st.win == WIN_LAST) begin
						nxt.werr = 3'h0;
					end
					if (st.werr + {2'h0, mis} >= RESYNC_ERRS && !st.resync_off) begin
						nxt.rx_st = RX_HUNT;
						nxt.cnt = 5'h0;
					end
				end
				default: begin
					nxt.rx_st = RX_HUNT;
					nxt.cnt = 5'h0;
				end
			endcase
		end
		if (rxl_rise || !st.tester_enable) begin
			nxt.rx_st = RX_HUNT;
			nxt.cnt = 5'h0;
		end
		err_inc = bit_inc & mis;
		if (upd) begin
			nxt.bit_hold = st.bit_cnt;
			nxt.err_hold = st.err_cnt;
			nxt.bit_cnt = {31'h0, bit_inc};
			nxt.err_cnt = {23'h0, err_inc};
		end else begin
			nxt.bit_cnt = st.bit_cnt + {31'h0, bit_inc};
			nxt.err_cnt = st.err_cnt + {23'h0, err_inc};
		end
		nxt.nz = nxt.err_hold != 24'h0;
		nxt.out_of_sync_flag = nxt.rx_st != RX_SYNC;
	end
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			st <= '0;
			st.rx_st <= RX_HUNT;
			st.out_of_sync_flag <= 1'b1;
		end else begin
			st <= nxt;
		end
	end
	// ****************************************
	// outputs
	// ****************************************
	assign AWREADY = st.awrdy;
	assign WREADY = st.wrdy;
	assign BVALID = st.bvalid;
	assign BRESP = st.bresp;
	assign ARREADY = st.arrdy;
	assign RVALID = st.rvalid;
	assign RDATA = st.rdata;
	assign RRESP = st.rresp;
	assign TX_DATA_OUT = st.tx_bit;
	assign TX_DATA_VALID = st.tx_vld;
	assign RX_BACKPLANE_DATA = st.thru;
	assign OUT_OF_SYNC_FLAG = st.out_of_sync_flag;
	assign ERROR_COUNT_NONZERO_FLAG = st.nz;
	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);
	sequence s_tx_load;
		tx_preset ##1 (tx_sr == $past(st.seed));
	endsequence
	chk_oos_state: assert property (OUT_OF_SYNC_FLAG == (st.rx_st != RX_SYNC))
		else $error("out-of-sync flag disagrees with sync state");
	chk_nonzero_flag: assert property (ERROR_COUNT_NONZERO_FLAG == (st.err_hold != 24'h0))
		else $error("nonzero flag disagrees with error count");
	chk_no_count_oos: assert property ((st.rx_st != RX_SYNC && !upd) |=> $stable(st.bit_cnt))
		else $error("bits counted while out of sync");
	chk_err_counting: assert property ((bit_inc && mis && !upd) |=>
		(st.err_cnt == $past(st.err_cnt) + 24'h1 && st.bit_cnt == $past(st.bit_cnt) + 32'h1))
		else $error("mismatch not counted");
	chk_update_capture: assert property (upd |=> (st.bit_hold == $past(st.bit_cnt) &&
		st.err_hold == $past(st.err_cnt) && st.bit_cnt <= 32'h1))
		else $error("update did not capture and clear");
	chk_tx_preset: assert property (tx_preset |-> s_tx_load)
		else $error("generator not preset on load");
	chk_load_needs_enable: assert property (!st.tester_enable |-> !tx_preset)
		else $error("pattern loaded while disabled");
	chk_resync_drop: assert property ((bit_inc && !st.resync_off && st.werr == 3'h5 && mis && !rxl_rise)
		|=> st.rx_st == RX_HUNT)
		else $error("six errors did not drop sync");
	chk_sync_after_32: assert property ((st.rx_st == RX_VERIFY && rx_step && !mis && st.cnt == SYNC_LAST
		&& !rxl_rise && st.tester_enable) |=> st.rx_st == RX_SYNC)
		else $error("32 matches did not give sync");
	chk_single_err: assert property ((tx_step && st.err_pend && !req) |=>
		(!st.err_pend && TX_DATA_OUT == ($past(tx_out) ^ ~$past(st.tx_pattern_invert))))
		else $error("pending error not applied once");
endmodule : bert_core

/* File: test/framer_model.sv */
// framer payload datapath model: issues payload slots and loops transmit back to receive
// assumes the bench loads a slot budget and pulses go to spend it
`timescale 1ns/1ns
module framer_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bench control
	input wire logic [15:0] budget,
	input wire logic go,
	input wire logic slow,
	// block side
	output logic slot,
	input wire logic tx_bit,
	input wire logic tx_valid,
	output logic rx_en,
	output logic rx_bit
);
	logic [15:0] left_r;
	logic [1:0] gap_r;
	logic fire;
	// ****************************************
	// slot pacing and loopback
	// ****************************************
	// slow mode spaces slots four cycles apart
	assign fire = left_r != 16'h0000 && (!slow || gap_r == 2'h0);
	always_ff @(posedge clk) begin
		if (rst) begin
			left_r <= 16'h0000;
			gap_r <= 2'h0;
			slot <= 1'b0;
			rx_en <= 1'b0;
			rx_bit <= 1'b0;
		end else begin
			gap_r <= gap_r + 2'h1;
			left_r <= go ? budget : left_r - 16'(fire);
			slot <= fire;
			rx_en <= tx_valid;
			// no payload between bits, so the line toggles rather than holding a stale value
			rx_bit <= tx_valid ? tx_bit : ~rx_bit;
		end
	end
endmodule : framer_model

/* File: test/tb_bert_core.sv */
// bench for the bit error rate tester: register tasks and pattern scenarios
// assumes the framer model loops the transmit payload into the receiver
`timescale 1ns/1ns
module tb_bert_core;
	import bert_pkg::*;
	localparam logic [31:0] EN = 32'h1 << CB_EN;
	localparam logic [31:0] LD = (32'h1 << CB_TXL) | (32'h1 << CB_RXL);
	localparam logic [31:0] SE = 32'h1 << CB_SERR;
	localparam logic [31:0] LP = 32'h1 << CB_LOCAL_MONITOR_UPDATE;
	localparam logic [31:0] TI = (32'h1 << CB_TINV) | (32'h1 << CB_RINV);
	localparam logic [31:0] PS = 32'h1 << CB_PSRC;
	localparam logic [31:0] AR = 32'h1 << CB_ARDIS;
	logic MCLK, RESET, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
	logic [7:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP;
	logic TX_PAYLOAD_EN, TX_DATA_OUT, TX_DATA_VALID, MANUAL_ERROR_INSERT_IN, RX_PAYLOAD_EN, RX_DATA_IN;
	logic RX_BACKPLANE_DATA, MONITOR_UPDATE_EVENT, OUT_OF_SYNC_FLAG, ERROR_COUNT_NONZERO_FLAG;
	logic [15:0] budget;
	logic go, slow, rx_prev, prev_ok;
	logic txq[$];
	int fails = 0;
	int num_checks = 0;
	bert_core bert_core_inst (.MCLK(MCLK), .RESET(RESET), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
		.WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY),
		.BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY),
		.RDATA(RDATA), .RRESP(RRESP), .TX_PAYLOAD_EN(TX_PAYLOAD_EN), .TX_DATA_OUT(TX_DATA_OUT),
		.TX_DATA_VALID(TX_DATA_VALID), .MANUAL_ERROR_INSERT_IN(MANUAL_ERROR_INSERT_IN),
		.RX_PAYLOAD_EN(RX_PAYLOAD_EN), .RX_DATA_IN(RX_DATA_IN), .RX_BACKPLANE_DATA(RX_BACKPLANE_DATA),
		.MONITOR_UPDATE_EVENT(MONITOR_UPDATE_EVENT), .OUT_OF_SYNC_FLAG(OUT_OF_SYNC_FLAG),
		.ERROR_COUNT_NONZERO_FLAG(ERROR_COUNT_NONZERO_FLAG));
	framer_model framer_model_inst (.clk(MCLK), .rst(RESET), .budget(budget), .go(go), .slow(slow),
		.slot(TX_PAYLOAD_EN), .tx_bit(TX_DATA_OUT), .tx_valid(TX_DATA_VALID), .rx_en(RX_PAYLOAD_EN),
		.rx_bit(RX_DATA_IN));
	// ****************************************
	// reporting and comparison
	// ****************************************
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	task automatic cmp32(input logic [31:0] g, input logic [31:0] e, input string m);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : cmp32
	task automatic cmp1(input logic g, input logic e, input string m);
		cmp32({31'h0, g}, {31'h0, e}, m);
	endtask : cmp1
	task automatic timeout;
		cmp1(1'b0, 1'b1, "wait ran out");
		close_out();
	endtask : timeout
	// ****************************************
	// bus and stream tasks
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw;
		logic w;
		int n;
		@(posedge MCLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
			if (!aw && AWREADY === 1'b1) begin
				aw = 1'b1;
				AWVALID <= 1'b0;
			end
			if (!w && WREADY === 1'b1) begin
				w = 1'b1;
				WVALID <= 1'b0;
			end
		end while (!(aw && w) && n < 100);
		while (BVALID !== 1'b1 && n < 200) begin
			@(posedge MCLK);
			n++;
		end
		BREADY <= 1'b0;
		if (n >= 200)
			timeout();
		cmp32({30'h0, BRESP}, {30'h0, er}, "write response");
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic t;
		int n;
		@(posedge MCLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		t = 1'b0;
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
			if (!t && ARREADY === 1'b1) begin
				t = 1'b1;
				ARVALID <= 1'b0;
			end
		end while (RVALID !== 1'b1 && n < 200);
		RREADY <= 1'b0;
		if (n >= 200)
			timeout();
		cmp32(RDATA, e, "read data");
		cmp32({30'h0, RRESP}, {30'h0, er}, "read response");
	endtask : rd
	task automatic go_slots(input int k);
		@(posedge MCLK);
		budget <= 16'(k);
		go <= 1'b1;
		@(posedge MCLK);
		go <= 1'b0;
	endtask : go_slots
	task automatic run(input int k);
		int base;
		int n;
		base = txq.size() + k;
		go_slots(k);
		for (n = 0; n < 8 * k + 20 && txq.size() < base; n++)
			@(posedge MCLK);
		if (txq.size() < base)
			timeout();
		repeat (4) @(posedge MCLK);
	endtask : run
	task automatic upd;
		@(posedge MCLK);
		MONITOR_UPDATE_EVENT <= 1'b1;
		@(posedge MCLK);
		MONITOR_UPDATE_EVENT <= 1'b0;
		repeat (2) @(posedge MCLK);
	endtask : upd
	task automatic load(input logic [31:0] cf, input logic [31:0] sd, input logic [31:0] c);
		wr(PCFG_OFS, cf, RESP_OKAY);
		wr(SEED_OFS, sd, RESP_OKAY);
		wr(CTRL_OFS, c, RESP_OKAY);
		wr(CTRL_OFS, c | LD, RESP_OKAY);
		wr(CTRL_OFS, c, RESP_OKAY);
		txq.delete();
	endtask : load
	// one generator step: returns the output bit and shifts s
	function automatic logic ref_step(inout logic [31:0] s, input logic [31:0] c);
		logic f;
		int n;
		int y;
		n = int'(c[4:0]) + 1;
		y = int'(c[12:8]) + 1;
		f = c[16] ? s[n-1] : (c[17] ? s[16] ^ s[19] : s[n-1] ^ s[y-1]);
		if (!c[16] && s[30:0] == 31'h0)
			f = 1'b1;
		ref_step = f | (c[17] && s[13:0] == 14'h0);
		s = {s[30:0], f};
	endfunction : ref_step
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		cmp1(OUT_OF_SYNC_FLAG, 1'b1, "oos at reset");
		cmp1(ERROR_COUNT_NONZERO_FLAG, 1'b0, "flag at reset");
		rd(STAT_OFS, 32'h2, RESP_OKAY);
		rd(8'h1C, 32'h0, RESP_SLVERR);
		wr(8'h1C, 32'h1, RESP_SLVERR);
		wr(STAT_OFS, 32'h1, RESP_OKAY);
		rd(STAT_OFS, 32'h2, RESP_OKAY);
		wr(CTRL_OFS, LD, RESP_OKAY);
		go_slots(8);
		repeat (40) @(posedge MCLK);
		cmp32(32'(txq.size()), 32'h0, "bits while off");
	endtask : t_reset
	task automatic t_gen;
		logic [31:0] cf[5] = '{32'h408, 32'h408, 32'h20253, 32'h10001, 32'h10017};
		logic [31:0] sd[5] = '{32'h1FF, 32'h0, 32'h0, 32'h2, 32'hFF200022};
		logic [4:0] iv = 5'b01001;
		logic [31:0] s;
		for (int i = 0; i < 5; i++) begin
			load(cf[i], sd[i], iv[i] ? EN | TI : EN);
			s = sd[i];
			run(48);
			for (int j = 0; j < 48; j++)
				cmp1(txq[j], ref_step(s, cf[i]) ^ iv[i], "tx bit");
			run(120);
			if (!cf[i][17])
				cmp1(OUT_OF_SYNC_FLAG, 1'b0, "sync");
		end
	endtask : t_gen
	task automatic t_count;
		load(32'h408, 32'h1FF, EN);
		upd();
		run(64);
		upd();
		rd(BITS_OFS, 32'h0, RESP_OKAY);
		run(100);
		upd();
		rd(BITS_OFS, 32'h64, RESP_OKAY);
		rd(STAT_OFS, 32'h0, RESP_OKAY);
		wr(CTRL_OFS, EN | SE, RESP_OKAY);
		run(50);
		upd();
		rd(BITS_OFS, 32'h32, RESP_OKAY);
		rd(ERRS_OFS, 32'h1, RESP_OKAY);
		cmp1(ERROR_COUNT_NONZERO_FLAG, 1'b1, "flag");
		wr(CTRL_OFS, EN | PS | SE, RESP_OKAY);
		run(20);
		@(posedge MCLK);
		MANUAL_ERROR_INSERT_IN <= 1'b1;
		@(posedge MCLK);
		MANUAL_ERROR_INSERT_IN <= 1'b0;
		run(50);
		wr(CTRL_OFS, EN | PS | LP, RESP_OKAY);
		repeat (2) @(posedge MCLK);
		rd(ERRS_OFS, 32'h1, RESP_OKAY);
	endtask : t_count
	task automatic t_rate;
		for (int n = 7; n >= 0; n--) begin
			wr(RATE_OFS, 32'(n), RESP_OKAY);
			rd(RATE_OFS, 32'(n), RESP_OKAY);
		end
		// 200 slow bits at one per ten: phase of the rate count cannot change the total
		wr(CTRL_OFS, EN | AR, RESP_OKAY);
		wr(RATE_OFS, 32'h1, RESP_OKAY);
		upd();
		slow <= 1'b1;
		run(200);
		wr(RATE_OFS, 32'h0, RESP_OKAY);
		upd();
		rd(ERRS_OFS, 32'h14, RESP_OKAY);
		cmp1(OUT_OF_SYNC_FLAG, 1'b0, "resync off");
		wr(CTRL_OFS, EN, RESP_OKAY);
		wr(RATE_OFS, 32'h1, RESP_OKAY);
		run(130);
		cmp1(OUT_OF_SYNC_FLAG, 1'b1, "resync");
		upd();
		run(40);
		upd();
		rd(BITS_OFS, 32'h0, RESP_OKAY);
	endtask : t_rate
	// ****************************************
	// clock, monitors and main sequence
	// ****************************************
	initial begin
		MCLK = 1'b0;
		forever #25 MCLK = ~MCLK;
	end
	always @(posedge MCLK) begin
		if (!RESET && TX_DATA_VALID === 1'b1)
			txq.push_back(TX_DATA_OUT);
		if (!RESET && prev_ok)
			cmp1(RX_BACKPLANE_DATA, rx_prev, "backplane");
		rx_prev <= RX_DATA_IN;
		prev_ok <= !RESET;
	end
	initial begin
		{RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h20;
		{AWADDR, ARADDR, WDATA, WSTRB} = {16'h0000, 32'h0, 4'hF};
		{MANUAL_ERROR_INSERT_IN, MONITOR_UPDATE_EVENT, go, slow, prev_ok} = 5'h00;
		budget = 16'h0000;
		repeat (6) @(posedge MCLK);
		RESET <= 1'b0;
		t_reset();
		t_gen();
		t_count();
		t_rate();
		close_out();
	end
endmodule : tb_bert_core
